/* smx_bus_matrix.sv */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module smx_bus_matrix (
  input wire logic aclk, // Matrix clock, shared with all masters.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire smx_pkg::smx_req_t [2:0] m_req, // Master requests by master number.
  output smx_pkg::smx_rsp_t [2:0] m_rsp, // Master answers by master number.
  output smx_pkg::smx_req_t [3:0] s_req, // Flash and bridge requests.
  input wire smx_pkg::smx_rsp_t [3:0] s_rsp, // Flash and bridge answers.
  input wire smx_pkg::smx_req_t [2:0] d_req, // Direct RAM ports 0, 2, 3.
  output smx_pkg::smx_rsp_t [2:0] d_rsp, // Direct RAM port answers.
  input wire logic [1:0] dma_wb_qos, // DMA write-back priority.
  input wire logic [1:0] dma_fetch_qos, // DMA descriptor fetch priority.
  input wire logic [1:0] dma_data_qos, // DMA data access priority.
  output smx_pkg::smx_ram_t ram, // Single RAM access with its priority.
  input wire logic [31:0] ram_rdata, // RAM read data.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp // Read response.
);
  import smx_pkg::*;
  typedef struct packed {
    smx_req_t [SMX_NUM_PERIPH-1:0] sreq;
    logic [SMX_NUM_PERIPH-1:0] busy;
    logic [SMX_NUM_PERIPH-1:0][1:0] owner;
    logic [SMX_NUM_MASTERS-1:0] mbusy;
    smx_rsp_t [SMX_NUM_MASTERS-1:0] mrsp;
    smx_rsp_t [SMX_NUM_DIRECT-1:0] drsp;
  } smx_top_state_t;
  smx_top_state_t st;
  smx_top_state_t next_st;
  smx_req_t [SMX_NUM_RAM_PORTS-1:0] ram_req;
  logic [SMX_NUM_RAM_PORTS-1:0][1:0] ram_qos;
  logic [SMX_NUM_RAM_PORTS-1:0] ram_done;
  logic [31:0] ram_done_rdata;
  logic [1:0] cpu_ram_priority;
  logic ram_busy;
  logic [31:0] ram_status;
  logic found;
  logic [2:0] master_port [SMX_NUM_MASTERS];
  logic [2:0] direct_port [SMX_NUM_DIRECT];

  // Each master has a RAM port of its own behind the matrix.
  assign master_port[SMX_MST_CPU] = SMX_PORT_CPU;
  assign master_port[SMX_MST_DEBUG] = SMX_PORT_DEBUG;
  assign master_port[SMX_MST_DMA] = SMX_PORT_DMA_DATA;
  assign direct_port[0] = SMX_PORT_TRACE;
  assign direct_port[1] = SMX_PORT_DMA_WB;
  assign direct_port[2] = SMX_PORT_DMA_FETCH;

  always_comb
  begin
    ram_req = '0;
    for (int d = 0; d < SMX_NUM_DIRECT; d++)
      ram_req[direct_port[d]] = d_req[d];
    for (int m = 0; m < SMX_NUM_MASTERS; m++)
    begin
      ram_req[master_port[m]] = m_req[m];
      ram_req[master_port[m]].valid = m_req[m].valid &&
                                      smx_decode(m_req[m].addr) == SMX_SLV_SRAM;
    end
    ram_qos = '0;
    ram_qos[SMX_PORT_TRACE] = SMX_QOS_TRACE_FIXED;
    ram_qos[SMX_PORT_RESERVED] = SMX_QOS_BACKGROUND;
    ram_qos[SMX_PORT_DMA_WB] = dma_wb_qos;
    ram_qos[SMX_PORT_DMA_FETCH] = dma_fetch_qos;
    ram_qos[SMX_PORT_CPU] = cpu_ram_priority;
    ram_qos[SMX_PORT_DMA_DATA] = dma_data_qos;
    ram_qos[SMX_PORT_DEBUG] = SMX_QOS_DEBUG_FIXED;
  end

  // Flash and bridges are switched independently of each other and of the RAM.
  always_comb
  begin
    next_st = st;
    found = 1'b0;
    for (int m = 0; m < SMX_NUM_MASTERS; m++)
      next_st.mrsp[m].ready = 1'b0;
    for (int d = 0; d < SMX_NUM_DIRECT; d++)
    begin
      next_st.drsp[d].ready = ram_done[direct_port[d]];
      if (ram_done[direct_port[d]])
        next_st.drsp[d].rdata = ram_done_rdata;
    end
    for (int s = 0; s < SMX_NUM_PERIPH; s++)
    begin
      if (st.busy[s])
      begin
        if (s_rsp[s].ready)
        begin
          next_st.sreq[s].valid = 1'b0;
          next_st.busy[s] = 1'b0;
          next_st.mbusy[st.owner[s]] = 1'b0;
          next_st.mrsp[st.owner[s]] = '{ready: 1'b1, rdata: s_rsp[s].rdata};
        end
      end
      else
      begin
        found = 1'b0;
        // The lowest master number takes an idle slave; the others wait unready.
        for (int m = 0; m < SMX_NUM_MASTERS; m++)
        begin
          if (!found && m_req[m].valid && !st.mrsp[m].ready && !st.mbusy[m] &&
              smx_decode(m_req[m].addr) == 3'(s))
          begin
            found = 1'b1;
            next_st.sreq[s] = m_req[m];
            next_st.busy[s] = 1'b1;
            next_st.owner[s] = 2'(m);
            next_st.mbusy[m] = 1'b1;
          end
        end
      end
    end
    for (int m = 0; m < SMX_NUM_MASTERS; m++)
    begin
      if (ram_done[master_port[m]])
        next_st.mrsp[m] = '{ready: 1'b1, rdata: ram_done_rdata};
      else if (m_req[m].valid && !st.mrsp[m].ready &&
               smx_decode(m_req[m].addr) == SMX_SLV_NONE)
        next_st.mrsp[m] = '{ready: 1'b1, rdata: 32'h00000000};
    end
  end

  assign m_rsp = st.mrsp;
  assign s_req = st.sreq;
  assign d_rsp = st.drsp;
  assign ram_status = {25'h0000000, ram_busy, 1'b0, ram.port, ram.qos};

  // Masters and matrix share this one clock edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  smx_ram_arbiter #(
    .NUM_PORTS(SMX_NUM_RAM_PORTS)
  ) u_ram_arbiter (
    .aclk(aclk),
    .aresetn(aresetn),
    .port_req(ram_req),
    .port_qos(ram_qos),
    .ram_rdata(ram_rdata),
    .done(ram_done),
    .done_rdata(ram_done_rdata),
    .ram(ram),
    .busy(ram_busy)
  );

  smx_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .status(ram_status),
    .cpu_ram_priority(cpu_ram_priority)
  );
endmodule : smx_bus_matrix
`default_nettype wire

/* smx_pkg.sv */
`default_nettype none
package smx_pkg;
  localparam int SMX_NUM_MASTERS = 3;
  localparam int SMX_NUM_PERIPH = 4;
  localparam int SMX_NUM_RAM_PORTS = 7;
  localparam int SMX_NUM_DIRECT = 3;
  // Master numbers.
  localparam int SMX_MST_CPU = 0;
  localparam int SMX_MST_DEBUG = 1;
  localparam int SMX_MST_DMA = 2;
  // Slave numbers; SMX_SLV_SRAM stands for the RAM port of the asking master.
  localparam logic [2:0] SMX_SLV_FLASH = 3'h0;
  localparam logic [2:0] SMX_SLV_BRIDGE_A = 3'h1;
  localparam logic [2:0] SMX_SLV_BRIDGE_B = 3'h2;
  localparam logic [2:0] SMX_SLV_BRIDGE_C = 3'h3;
  localparam logic [2:0] SMX_SLV_SRAM = 3'h4;
  localparam logic [2:0] SMX_SLV_NONE = 3'h7;
  localparam logic [2:0] SMX_PORT_TRACE = 3'h0;
  localparam logic [2:0] SMX_PORT_RESERVED = 3'h1;
  localparam logic [2:0] SMX_PORT_DMA_WB = 3'h2;
  localparam logic [2:0] SMX_PORT_DMA_FETCH = 3'h3;
  localparam logic [2:0] SMX_PORT_CPU = 3'h4;
  localparam logic [2:0] SMX_PORT_DMA_DATA = 3'h5;
  localparam logic [2:0] SMX_PORT_DEBUG = 3'h6;
  localparam logic [3:0] SMX_REGION_FLASH = 4'h0;
  localparam logic [3:0] SMX_REGION_SRAM = 4'h2;
  localparam logic [7:0] SMX_REGION_BRIDGE_A = 8'h40;
  localparam logic [7:0] SMX_REGION_BRIDGE_B = 8'h41;
  localparam logic [7:0] SMX_REGION_BRIDGE_C = 8'h42;
  typedef enum logic [1:0] {
    SMX_QOS_BACKGROUND = 2'h0,
    SMX_QOS_BANDWIDTH = 2'h1,
    SMX_QOS_LATENCY = 2'h2,
    SMX_QOS_CRITICAL = 2'h3
  } smx_qos_t;
  localparam logic [1:0] SMX_QOS_TRACE_FIXED = SMX_QOS_CRITICAL;
  localparam logic [1:0] SMX_QOS_DEBUG_FIXED = SMX_QOS_BANDWIDTH;
  localparam logic [31:0] SMX_REG_CPU_RAM_PRIORITY = 32'h41007110;
  localparam logic [31:0] SMX_REG_RAM_STATUS = 32'h41007114;
  localparam int SMX_CPU_PRIO_LSB = 0;
  localparam int SMX_CPU_PRIO_MSB = 1;
  localparam logic [1:0] SMX_CPU_PRIO_RESET = 2'h0;
  localparam logic [1:0] SMX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMX_RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } smx_req_t;
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
  } smx_rsp_t;
  typedef struct packed {
    logic en;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] qos;
    logic [2:0] port;
  } smx_ram_t;
  function automatic logic [2:0] smx_decode(input logic [31:0] addr);
    logic [2:0] slv;
    slv = SMX_SLV_NONE;
    if (addr[31:28] == SMX_REGION_FLASH)
      slv = SMX_SLV_FLASH;
    else if (addr[31:28] == SMX_REGION_SRAM)
      slv = SMX_SLV_SRAM;
    else if (addr[31:24] == SMX_REGION_BRIDGE_A)
      slv = SMX_SLV_BRIDGE_A;
    else if (addr[31:24] == SMX_REGION_BRIDGE_B)
      slv = SMX_SLV_BRIDGE_B;
    else if (addr[31:24] == SMX_REGION_BRIDGE_C)
      slv = SMX_SLV_BRIDGE_C;
    return slv;
  endfunction : smx_decode
endpackage : smx_pkg
`default_nettype wire

/* smx_ram_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module smx_ram_arbiter #(
  parameter int NUM_PORTS = 7
) (
  input wire logic aclk, // Matrix clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire smx_pkg::smx_req_t [NUM_PORTS-1:0] port_req, // Held RAM requests.
  input wire logic [NUM_PORTS-1:0][1:0] port_qos, // Priority of each port.
  input wire logic [31:0] ram_rdata, // RAM read data, one cycle after en.
  output logic [NUM_PORTS-1:0] done, // Answer strobe per port.
  output logic [31:0] done_rdata, // Read data for the answered port.
  output smx_pkg::smx_ram_t ram, // Access to the RAM, priority included.
  output logic busy // An access is under way.
);
  import smx_pkg::*;
  typedef enum logic [1:0] {SMX_ARB_IDLE, SMX_ARB_ACCESS, SMX_ARB_ANSWER} smx_arb_phase_t;
  typedef struct packed {
    smx_arb_phase_t phase;
    smx_ram_t ram;
    logic [NUM_PORTS-1:0] aged;
    logic [NUM_PORTS-1:0] answered;
  } smx_arb_state_t;
  smx_arb_state_t st;
  smx_arb_state_t next_st;
  logic found;
  logic [1:0] best_qos;
  logic [2:0] best_port;
  logic eligible;

  always_comb
  begin
    next_st = st;
    next_st.ram.en = 1'b0;
    next_st.answered = '0;
    done = '0;
    found = 1'b0;
    best_qos = SMX_QOS_BACKGROUND;
    best_port = SMX_PORT_TRACE;
    eligible = 1'b0;
    unique case (st.phase)
      SMX_ARB_IDLE:
      begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
          // Low levels wait a cycle in the aged flag first.
          eligible = port_req[p].valid && !st.answered[p] &&
                     (port_qos[p] >= SMX_QOS_LATENCY || st.aged[p]);
          // Strictly higher level replaces; ties keep the lower port.
          if (eligible && (!found || port_qos[p] > best_qos))
          begin
            found = 1'b1;
            best_qos = port_qos[p];
            best_port = 3'(p);
          end
        end
        if (found)
        begin
          next_st.phase = SMX_ARB_ACCESS;
          next_st.ram.en = 1'b1;
          next_st.ram.write = port_req[best_port].write;
          next_st.ram.addr = port_req[best_port].addr;
          next_st.ram.wdata = port_req[best_port].wdata;
          next_st.ram.qos = best_qos;
          next_st.ram.port = best_port;
        end
      end
      SMX_ARB_ACCESS:
        next_st.phase = SMX_ARB_ANSWER;
      SMX_ARB_ANSWER:
      begin
        done[st.ram.port] = 1'b1;
        next_st.answered[st.ram.port] = 1'b1;
        next_st.phase = SMX_ARB_IDLE;
      end
    endcase
    for (int p = 0; p < NUM_PORTS; p++)
      next_st.aged[p] = port_req[p].valid && !st.answered[p] && !next_st.answered[p];
  end

  assign done_rdata = ram_rdata;
  assign ram = st.ram;
  assign busy = (st.phase != SMX_ARB_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : smx_ram_arbiter
`default_nettype wire

/* smx_axil_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module smx_axil_regs (
  input wire logic aclk, // Matrix clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  input wire logic [31:0] status, // Arbiter state for the status register.
  output logic [1:0] cpu_ram_priority // Core RAM priority field.
);
  import smx_pkg::*;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] cpu_ram_priority;
  } smx_axil_state_t;
  localparam smx_axil_state_t SMX_AXIL_RESET = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1, cpu_ram_priority: SMX_CPU_PRIO_RESET, default: '0};
  smx_axil_state_t st;
  smx_axil_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (next_st.aw_have && next_st.w_have && !st.bvalid)
    begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = SMX_RESP_OKAY;
      if (next_st.awaddr == SMX_REG_CPU_RAM_PRIORITY)
      begin
        if (next_st.wstrb0)
          next_st.cpu_ram_priority = next_st.wdata[SMX_CPU_PRIO_MSB:SMX_CPU_PRIO_LSB];
      end
      else if (next_st.awaddr != SMX_REG_RAM_STATUS)
        next_st.bresp = SMX_RESP_SLVERR;
    end
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready = !next_st.w_have && !next_st.bvalid;
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = SMX_RESP_OKAY;
      next_st.rdata = '0;
      if (s_axi_araddr == SMX_REG_CPU_RAM_PRIORITY)
        next_st.rdata[SMX_CPU_PRIO_MSB:SMX_CPU_PRIO_LSB] = st.cpu_ram_priority;
      else if (s_axi_araddr == SMX_REG_RAM_STATUS)
        next_st.rdata = status;
      else
        next_st.rresp = SMX_RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cpu_ram_priority = st.cpu_ram_priority;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= SMX_AXIL_RESET;
    else
      st <= next_st;
  end
endmodule : smx_axil_regs
`default_nettype wire

/* smx_bus_matrix_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module smx_bus_matrix_sva (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire smx_pkg::smx_req_t [2:0] m_req, // Masters.
  input wire smx_pkg::smx_rsp_t [2:0] m_rsp, // Master answers.
  input wire smx_pkg::smx_req_t [3:0] s_req, // Slaves.
  input wire smx_pkg::smx_rsp_t [3:0] s_rsp, // Slave answers.
  input wire smx_pkg::smx_req_t [2:0] d_req, // Direct ports.
  input wire smx_pkg::smx_rsp_t [2:0] d_rsp, // Direct answers.
  input wire logic [1:0] dma_wb_qos, // Level.
  input wire logic [1:0] dma_fetch_qos, // Level.
  input wire logic [1:0] dma_data_qos, // Level.
  input wire smx_pkg::smx_ram_t ram, // RAM access.
  input wire logic s_axi_awvalid, // AW.
  input wire logic s_axi_awready, // AW.
  input wire logic s_axi_wvalid, // W.
  input wire logic s_axi_wready, // W.
  input wire logic s_axi_bvalid, // B.
  input wire logic s_axi_arvalid, // AR.
  input wire logic s_axi_arready, // AR.
  input wire logic s_axi_rvalid // R.
);
  import smx_pkg::*;
  logic [6:0] vld, rdy, seen, elig;
  logic [6:0][1:0] lvl, lvl_q;
  logic beaten, s_done;
  // Requests by RAM port; the core's level lives inside, so it is never a rival here.
  always_comb
  begin
    vld = {m_req[1].valid && m_req[1].addr[31:28] == SMX_REGION_SRAM,
      m_req[2].valid && m_req[2].addr[31:28] == SMX_REGION_SRAM,
      m_req[0].valid && m_req[0].addr[31:28] == SMX_REGION_SRAM,
      d_req[2].valid, d_req[1].valid, 1'b0, d_req[0].valid};
    rdy = {m_rsp[1].ready, m_rsp[2].ready, m_rsp[0].ready, d_rsp[2].ready, d_rsp[1].ready,
      1'b0, d_rsp[0].ready};
    lvl = {SMX_QOS_DEBUG_FIXED, dma_data_qos, 2'h0, dma_fetch_qos, dma_wb_qos, 2'h0,
      SMX_QOS_TRACE_FIXED};
    beaten = 1'b0;
    for (int q = 0; q < 7; q++)
      if (elig[q] && q != 4 && q != int'(ram.port)
          && (lvl_q[q] > ram.qos || (lvl_q[q] == ram.qos && q < int'(ram.port))))
        beaten = 1'b1;
    s_done = 1'b0;
    for (int i = 0; i < 4; i++)
      s_done = s_done | (s_req[i].valid & s_rsp[i].ready);
  end
  always_ff @(posedge aclk)
  begin
    lvl_q <= lvl;
    seen <= aresetn ? vld & ~rdy : 7'h00;
    elig <= aresetn ? vld & seen & ~rdy : 7'h00;
  end
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  one_access_a: assert property (ram.en |=> !ram.en [*2])
    else $error("RAM access overlap");
  ram_answer_a: assert property (ram.en |-> ##2 rdy[ram.port])
    else $error("RAM answer missing");
  port_level_a: assert property (
    ram.en && ram.port != SMX_PORT_CPU |-> ram.qos == lvl_q[ram.port])
    else $error("RAM level wrong");
  no_reserved_a: assert property (ram.en |-> ram.port != SMX_PORT_RESERVED)
    else $error("Reserved port used");
  low_wait_a: assert property (ram.en && ram.qos < 2'h2 |-> elig[ram.port])
    else $error("Low level granted too early");
  rank_order_a: assert property (ram.en |-> !beaten)
    else $error("Wrong grant order");
  slave_hold_a: assert property (
    s_req[1].valid && !s_rsp[1].ready |=> s_req[1].valid && $stable(s_req[1].addr))
    else $error("Slave request dropped");
  slave_answer_a: assert property (
    s_done |=> m_rsp[0].ready || m_rsp[1].ready || m_rsp[2].ready)
    else $error("Slave answer lost");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("Write response missing");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read response missing");
  cover property (ram.en && s_req[0].valid);
  cover property (ram.en && ram.qos == 2'h0);
  cover property (s_axi_bvalid);
endmodule : smx_bus_matrix_sva
bind smx_bus_matrix smx_bus_matrix_sva i_smx_bus_matrix_sva (.aclk, .aresetn, .m_req, .m_rsp,
  .s_req, .s_rsp, .d_req, .d_rsp, .dma_wb_qos, .dma_fetch_qos, .dma_data_qos, .ram,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

/* smx_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module smx_far_model #(
  parameter int DLY = 3
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic slow, // Stretch slave answers by DLY cycles.
  input wire smx_pkg::smx_req_t [3:0] s_req, // Slave requests.
  output smx_pkg::smx_rsp_t [3:0] s_rsp, // Slave answers.
  input wire smx_pkg::smx_ram_t ram, // RAM access.
  output logic [31:0] ram_rdata // RAM read data.
);
  import smx_pkg::*;
  logic [3:0][2:0] cnt;
  logic [31:0] mem [logic [31:0]];
  // Outside an answer the data shows the inverse, so stale data cannot pass.
  always_comb
    for (int i = 0; i < 4; i++)
    begin
      s_rsp[i].ready = s_req[i].valid && (!slow || cnt[i] == 3'(DLY));
      s_rsp[i].rdata = {32{~s_rsp[i].ready}} ^ s_req[i].addr ^ 32'h0F0F0F0F;
    end
  always_ff @(posedge aclk)
    for (int i = 0; i < 4; i++)
      cnt[i] <= (aresetn && s_req[i].valid && !s_rsp[i].ready) ? cnt[i] + 3'h1 : 3'h0;
  always @(posedge aclk)
  begin
    if (ram.en && ram.write)
      mem[ram.addr] = ram.wdata;
    if (!aresetn)
      ram_rdata <= 32'h00000000;
    else if (ram.en && !ram.write && mem.exists(ram.addr))
      ram_rdata <= mem[ram.addr];
    else
      ram_rdata <= ~ram_rdata;
  end
endmodule : smx_far_model
`default_nettype wire

/* smx_bus_matrix_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module smx_bus_matrix_tb;
  import smx_pkg::*;
  logic aclk, aresetn, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, ram_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, dma_wb_qos, dma_fetch_qos, dma_data_qos, rs;
  smx_req_t [2:0] m_req;
  smx_req_t [2:0] d_req;
  smx_req_t [3:0] s_req;
  smx_rsp_t [2:0] m_rsp;
  smx_rsp_t [2:0] d_rsp;
  smx_rsp_t [3:0] s_rsp;
  smx_ram_t ram;
  logic [2:0] gport[$];
  logic [1:0] gqos[$];
  logic [31:0] rdv[4];
  int nv[4];
  int n, err_total, n_checks;
  logic [2:0] order[8] = '{3'h0, 3'h2, 3'h5, 3'h6, 3'h2, 3'h3, 3'h4, 3'h6};
  localparam logic [31:0] CREG = SMX_REG_CPU_RAM_PRIORITY;
  smx_bus_matrix i_smx_bus_matrix (.aclk, .aresetn, .m_req, .m_rsp, .s_req, .s_rsp, .d_req,
    .d_rsp, .dma_wb_qos, .dma_fetch_qos, .dma_data_qos, .ram, .ram_rdata, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  smx_far_model i_smx_far_model (.aclk, .aresetn, .slow, .s_req, .s_rsp, .ram, .ram_rdata);
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (ram.en === 1'b1)
    begin
      gport.push_back(ram.port);
      gqos.push_back(ram.qos);
    end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 60)
    begin
      err_total++;
      end_sim();
    end
  endtask : tmo
  task automatic xfer(input bit dp, input int i, input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rdo, output int k);
    if (dp)
      d_req[i] <= smx_req_t'{1'b1, wr, a, wd};
    else
      m_req[i] <= smx_req_t'{1'b1, wr, a, wd};
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end while ((dp ? d_rsp[i].ready : m_rsp[i].ready) !== 1'b1 && k < 60);
    rdo = dp ? d_rsp[i].rdata : m_rsp[i].rdata;
    if (dp)
      d_req[i].valid <= 1'b0;
    else
      m_req[i].valid <= 1'b0;
    tmo(k);
    @(posedge aclk);
  endtask : xfer
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask : axi_rd
  initial
  begin
    aresetn = 1'b0;
    m_req = '0;
    d_req = '0;
    slow = 1'b0;
    dma_wb_qos = 2'h2;
    dma_fetch_qos = 2'h1;
    dma_data_qos = 2'h2;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = '0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(CREG);
    chk(rd, 32'h00000000);
    axi_wr(CREG, 32'hFFFFFFFF, 4'hF);
    chk(32'(rs), 32'(SMX_RESP_OKAY));
    axi_wr(CREG, 32'h00000001, 4'hE);
    axi_rd(CREG);
    chk(rd, 32'h00000003);
    axi_rd(32'h41007200);
    chk(32'(rs), 32'(SMX_RESP_SLVERR));
    $display("test registers done");
    xfer(1'b0, 0, 1'b1, 32'h20000010, 32'hC0DE1234, rd, n);
    for (int q = 0; q < 4; q++)
    begin
      axi_wr(CREG, 32'(q), 4'hF);
      gqos.delete();
      gport.delete();
      xfer(1'b0, 0, 1'b0, 32'h20000010, 32'h0, rd, n);
      chk(rd, 32'hC0DE1234);
      chk(32'(n), q < 2 ? 32'h5 : 32'h4);
      chk(32'(gqos[0]), 32'(q));
      chk(32'(gport[0]), 32'(SMX_PORT_CPU));
    end
    $display("test levels done");
    fork
      xfer(1'b0, 0, 1'b0, 32'h00000100, 32'h0, rdv[0], nv[0]);
      xfer(1'b0, 2, 1'b0, 32'h41000200, 32'h0, rdv[1], nv[1]);
      xfer(1'b0, 1, 1'b1, 32'h20000020, 32'h5, rdv[2], nv[2]);
    join
    chk(rdv[0], 32'h0F0F0E0F);
    chk(rdv[1], 32'h4E0F0D0F);
    chk(32'(nv[0] + nv[1]), 32'h6);
    chk(32'(nv[2]), 32'h5);
    slow <= 1'b1;
    xfer(1'b0, 0, 1'b0, 32'h40000040, 32'h0, rd, n);
    chk(32'(n), 32'h6);
    slow <= 1'b0;
    xfer(1'b0, 1, 1'b0, 32'h30000000, 32'h0, rd, n);
    chk(rd, 32'h0);
    $display("test paths done");
    for (int c = 0; c < 2; c++)
    begin
      dma_wb_qos <= c ? 2'h1 : 2'h2;
      axi_wr(CREG, 32'h1, 4'hF);
      gport.delete();
      fork
        xfer(1'b1, c, 1'b0, 32'h20000100, 32'h0, rdv[0], nv[0]);
        xfer(1'b1, c + 1, 1'b0, 32'h20000104, 32'h0, rdv[1], nv[1]);
        xfer(1'b0, c ? 0 : 2, 1'b0, 32'h20000108, 32'h0, rdv[2], nv[2]);
        xfer(1'b0, 1, 1'b0, 32'h2000010C, 32'h0, rdv[3], nv[3]);
      join
      for (int k = 0; k < 4; k++)
        chk(32'(gport[k]), 32'(order[4 * c + k]));
    end
    axi_rd(SMX_REG_RAM_STATUS);
    chk(rd, 32'h00000019);
    $display("test collisions done");
    end_sim();
  end
endmodule : smx_bus_matrix_tb
`default_nettype wire
